// ===== dv/kbd_core_model.sv
// behavioural model of the controller core and wakeup logic beside the block
`timescale 1ns/1ps
`default_nettype none

module kbd_core_model (
   input  wire logic       clock_i,
   input  wire logic [5:0] cmd_i,
   output var logic        aux_o,
   output var logic        kbd_irq_o,
   output var logic        mouse_irq_o,
   output var logic        kbd_clr_o,
   output var logic        mouse_clr_o,
   output var logic        key_hit_o,
   output var logic        slow_clk_o
);
   logic [1:0] div_ff;

   // core levels follow the command word, which moves just after an edge
   assign {aux_o, kbd_irq_o, mouse_irq_o, kbd_clr_o, mouse_clr_o, key_hit_o} = cmd_i;

   // slow clock stand-in starts low
   initial begin
      slow_clk_o = 1'b0;
      div_ff = 2'h0;
   end

   // slow clock stand-in runs free, far faster than real to keep the run short
   always @(posedge clock_i) begin
      div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
      if (div_ff == 2'h2) begin
         slow_clk_o <= !slow_clk_o;
      end
   end
endmodule : kbd_core_model

`default_nettype wire

// ===== dv/keyboard_wake_config_bench.sv
// self-checking bench of the keyboard wake configuration block
`timescale 1ns/1ps
`default_nettype none

module keyboard_wake_config_bench;
   logic                         clock_i = 1'b0;
   logic                         rst_i;
   keyboard_wake_pkg::reg_req_t   req;
   keyboard_wake_pkg::ps2_lines_t kbd_pin, mouse_pin, kbd_core, mouse_core;
   logic [7:0]                   rdata;
   logic                         kwake, mwake, aux_core, aux_out, kirq_c, mirq_c, kclr, mclr;
   logic                         kirq, mirq, p92, slow_pin, gated, absent, off, hit, irq;
   logic [5:0]                   core_cmd;
   int                           mismatches = 0;
   int                           n_checks = 0;

   // ---------------------------------------------------------------
   // instances and clock
   // ---------------------------------------------------------------
   keyboard_wake_config keyboard_wake_config_i (.clock_i(clock_i), .rst_i(rst_i),
      .reg_req_i(req), .reg_rdata_o(rdata), .kbd_pin_i(kbd_pin), .mouse_pin_i(mouse_pin),
      .kbd_core_o(kbd_core), .mouse_core_o(mouse_core), .kbd_data_line_wake_o(kwake),
      .mouse_data_line_wake_o(mwake), .aux_port_core_i(aux_core), .aux_port_output_o(aux_out),
      .kbd_irq_core_i(kirq_c), .mouse_irq_core_i(mirq_c), .kbd_irq_clr_i(kclr),
      .mouse_irq_clr_i(mclr), .kbd_irq_o(kirq), .mouse_irq_o(mirq), .port92_en_o(p92),
      .slow_clock_pin_i(slow_pin), .slow_clock_gated_o(gated), .slow_clock_absent_o(absent),
      .key_wake_off_o(off), .key_wake_hit_i(hit), .irq_o(irq));

   kbd_core_model kbd_core_model_i (.clock_i(clock_i), .cmd_i(core_cmd), .aux_o(aux_core),
      .kbd_irq_o(kirq_c),
      .mouse_irq_o(mirq_c), .kbd_clr_o(kclr), .mouse_clr_o(mclr), .key_hit_o(hit),
      .slow_clk_o(slow_pin));

   always #10 clock_i = ~clock_i;

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick

   // core levels: {aux, kbd irq, mouse irq, kbd clear, mouse clear, key hit}
   task automatic drive(input logic [5:0] v);
      @(posedge clock_i);
      core_cmd <= v;
   endtask : drive

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock_i);
      req.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock_i);
      req.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_chk

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic reset_values();
      chk({7'h00, aux_out}, 8'h01);
      chk({6'h00, p92, kirq}, 8'h00);
      chk({6'h00, absent, off}, 8'h00);
      rd_chk(16'h07f0, 8'h00);
      rd_chk(16'h0af0, 8'h00);
      wr(16'h07f0, 8'hff);
      rd_chk(16'h07f0, 8'hfc);
      wr(16'h0af0, 8'hff);
      rd_chk(16'h0af0, 8'h03);
      chk({5'h00, p92, absent, off}, 8'h07);
      wr(16'h07f0, 8'h00);
      wr(16'h0af0, 8'h00);
   endtask : reset_values

   // reserved writes must not leak into the select register
   task automatic reserved();
      for (int a = 16'h07f1; a <= 16'h07ff; a++) begin
         wr(a[15:0], 8'hff);
         rd_chk(a[15:0], 8'h00);
      end
      wr(16'h0100, 8'hff);
      rd_chk(16'h0100, 8'h00);
      rd_chk(16'h07f0, 8'h00);
   endtask : reserved

   task automatic aux_polarity();
      for (int i = 0; i < 4; i++) begin
         wr(16'h07f0, {i[1], 7'h00});
         drive({i[0], 5'h00});
         tick(2);
         chk({7'h00, aux_out}, {7'h00, i[1] ? i[0] : !i[0]});
      end
   endtask : aux_polarity

   task automatic isolation();
      logic [7:0] c;
      logic [1:0] pv;
      for (int i = 0; i < 4; i++) begin
         c = {1'b0, i[1:0], 5'h00};
         pv = i[0] ? 2'b10 : 2'b01;  // isolated keyboard sees a low data pin
         wr(16'h07f0, c);
         kbd_pin <= pv;
         mouse_pin <= ~pv;
         tick(2);
         chk({6'h00, kbd_core}, {6'h00, c[5] ? 2'b11 : pv});
         chk({6'h00, mouse_core}, {6'h00, c[6] ? 2'b11 : ~pv});
         chk({6'h00, kwake, mwake}, {6'h00, pv[0], ~pv[0]});
      end
   endtask : isolation

   task automatic slow_clock(input logic off_bit);
      logic p;
      wr(16'h0af0, {6'h00, off_bit, 1'b0});
      tick(1);
      repeat (12) begin
         p = slow_pin;
         tick(1);
         chk({7'h00, gated}, {7'h00, p & !off_bit});
      end
   endtask : slow_clock

   // m picks the mouse path, latched picks the latched-only mode
   task automatic irq_case(input logic m, input logic latched);
      wr(16'h07f0, {3'h0, m & latched, !m & latched, 3'h0});
      drive(m ? 6'h08 : 6'h10);
      tick(2);
      chk({7'h00, m ? mirq : kirq}, 8'h01);
      drive(6'h00);
      tick(2);
      chk({7'h00, m ? mirq : kirq}, {7'h00, latched});
      drive(m ? 6'h02 : 6'h04);
      drive(6'h00);
      tick(2);
      chk({7'h00, m ? mirq : kirq}, 8'h00);
   endtask : irq_case

   // key hits count only while the wake logic runs
   task automatic events();
      rd_chk(16'h0ae0, 8'h03);
      wr(16'h0af0, 8'h02);
      drive(6'h01);
      drive(6'h00);
      rd_chk(16'h0ae0, 8'h03);
      wr(16'h0af0, 8'h00);
      drive(6'h01);
      drive(6'h00);
      rd_chk(16'h0ae0, 8'h07);
      chk({7'h00, irq}, 8'h00);
      wr(16'h0ae1, 8'h01);
      tick(1);
      chk({7'h00, irq}, 8'h01);
      wr(16'h0ae0, 8'h01);
      tick(1);
      chk({7'h00, irq}, 8'h00);
      rd_chk(16'h0ae0, 8'h06);
      wr(16'h0ae1, 8'h07);
      tick(1);
      chk({7'h00, irq}, 8'h01);
      wr(16'h0ae0, 8'h06);
      tick(1);
      chk({7'h00, irq}, 8'h00);
      rd_chk(16'h0ae0, 8'h00);
   endtask : events

   // ---------------------------------------------------------------
   // main sequence and hang guard
   // ---------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      req = '0;
      core_cmd = 6'h00;
      kbd_pin = 2'b11;
      mouse_pin = 2'b11;
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      tick(1);
      reset_values();
      reserved();
      aux_polarity();
      isolation();
      slow_clock(1'b1);
      slow_clock(1'b0);
      for (int i = 0; i < 4; i++) begin
         irq_case(i[1], i[0]);
      end
      events();
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      mismatches++;
      complete_run();
   end
endmodule : keyboard_wake_config_bench

`default_nettype wire

// ===== rtl/keyboard_wake_config.sv
// keyboard select and slow clock configuration with line isolation and irq muxing
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "keyboard_wake_config_defines.svh"

module keyboard_wake_config (
   input  wire logic                          clock_i,
   input  wire logic                          rst_i,
   input  wire keyboard_wake_pkg::reg_req_t   reg_req_i,
   output logic [7:0]                         reg_rdata_o,
   input  wire keyboard_wake_pkg::ps2_lines_t kbd_pin_i,
   input  wire keyboard_wake_pkg::ps2_lines_t mouse_pin_i,
   output keyboard_wake_pkg::ps2_lines_t      kbd_core_o,
   output keyboard_wake_pkg::ps2_lines_t      mouse_core_o,
   output logic                               kbd_data_line_wake_o,
   output logic                               mouse_data_line_wake_o,
   input  wire logic                          aux_port_core_i,
   output logic                               aux_port_output_o,
   input  wire logic                          kbd_irq_core_i,
   input  wire logic                          mouse_irq_core_i,
   input  wire logic                          kbd_irq_clr_i,
   input  wire logic                          mouse_irq_clr_i,
   output logic                               kbd_irq_o,
   output logic                               mouse_irq_o,
   output logic                               port92_en_o,
   input  wire logic                          slow_clock_pin_i,
   output logic                               slow_clock_gated_o,
   output logic                               slow_clock_absent_o,
   output logic                               key_wake_off_o,
   input  wire logic                          key_wake_hit_i,
   output logic                               irq_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   keyboard_wake_pkg::state_t state_ff;
   keyboard_wake_pkg::state_t nxt_state;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   logic       sel_kbd_dev;
   logic       sel_pme_dev;
   logic [7:0] idx;
   logic       hit_kbd_cfg;
   logic       hit_kbd_rsv;
   logic       hit_slow_cfg;
   logic       hit_stat;
   logic       hit_mask;
   logic [7:0] evt_now;

   // split the address into logical device and index
   assign idx          = reg_req_i.addr[7:0];
   assign sel_kbd_dev  = (reg_req_i.addr[15:8] == `KWC_LDN_KBD);
   assign sel_pme_dev  = (reg_req_i.addr[15:8] == `KWC_LDN_PME);
   assign hit_kbd_cfg  = sel_kbd_dev && (idx == `KWC_IDX_CFG);
   assign hit_kbd_rsv  = sel_kbd_dev && (idx >= `KWC_IDX_RSV_LO)
                         && (idx <= `KWC_IDX_RSV_HI);
   assign hit_slow_cfg = sel_pme_dev && (idx == `KWC_IDX_CFG);
   assign hit_stat     = sel_pme_dev && (idx == `KWC_IDX_IRQ_STAT);
   assign hit_mask     = sel_pme_dev && (idx == `KWC_IDX_IRQ_MASK);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;

      // register writes; reserved bits are masked off, reserved indices ignored
      if (reg_req_i.wr && hit_kbd_cfg) begin
         nxt_state.kbd_cfg = reg_req_i.wdata & `KWC_KBD_WR_MASK;
      end
      if (reg_req_i.wr && hit_slow_cfg) begin
         nxt_state.slow_cfg = reg_req_i.wdata & `KWC_SLOW_WR_MASK;
      end
      if (reg_req_i.wr && hit_mask) begin
         nxt_state.evt_mask = reg_req_i.wdata & `KWC_EVT_WR_MASK;
      end

      // read data, valid the cycle after the strobe; unmapped reads give zero
      nxt_state.rdata = 8'h00;
      if (reg_req_i.rd) begin
         if (hit_kbd_cfg) begin
            nxt_state.rdata = state_ff.kbd_cfg;
         end else if (hit_kbd_rsv) begin
            nxt_state.rdata = 8'h00;
         end else if (hit_slow_cfg) begin
            nxt_state.rdata = state_ff.slow_cfg;
         end else if (hit_stat) begin
            nxt_state.rdata = state_ff.evt_stat;
         end else if (hit_mask) begin
            nxt_state.rdata = state_ff.evt_mask;
         end
      end

      // latched core interrupts: rising edge sets, clear input drops, set wins
      nxt_state.kbd_core_prev   = kbd_irq_core_i;
      nxt_state.mouse_core_prev = mouse_irq_core_i;
      if (kbd_irq_clr_i) begin
         nxt_state.kbd_latch = 1'b0;
      end
      if (kbd_irq_core_i && !state_ff.kbd_core_prev) begin
         nxt_state.kbd_latch = 1'b1;
      end
      if (mouse_irq_clr_i) begin
         nxt_state.mouse_latch = 1'b0;
      end
      if (mouse_irq_core_i && !state_ff.mouse_core_prev) begin
         nxt_state.mouse_latch = 1'b1;
      end

      // interrupt muxing: the AND form drops the output once the core lets go
      if (state_ff.kbd_cfg[`KWC_KBD_KBD_IRQ_LATCH_SEL]) begin
         nxt_state.kbd_irq = state_ff.kbd_latch;
      end else begin
         nxt_state.kbd_irq = kbd_irq_core_i && state_ff.kbd_latch;
      end
      if (state_ff.kbd_cfg[`KWC_KBD_MOUSE_IRQ_LATCH_SEL]) begin
         nxt_state.mouse_irq = state_ff.mouse_latch;
      end else begin
         nxt_state.mouse_irq = mouse_irq_core_i && state_ff.mouse_latch;
      end

      // aux port polarity
      if (state_ff.kbd_cfg[`KWC_KBD_AUX_POL]) begin
         nxt_state.aux_out = aux_port_core_i;
      end else begin
         nxt_state.aux_out = !aux_port_core_i;
      end

      // isolation parks the core side at the idle high level of the lines
      if (state_ff.kbd_cfg[`KWC_KBD_KEY_ISO]) begin
         nxt_state.kbd_core = '{clk: 1'b1, data: 1'b1};
      end else begin
         nxt_state.kbd_core = kbd_pin_i;
      end
      if (state_ff.kbd_cfg[`KWC_KBD_MOUSE_ISO]) begin
         nxt_state.mouse_core = '{clk: 1'b1, data: 1'b1};
      end else begin
         nxt_state.mouse_core = mouse_pin_i;
      end

      // wake path taps the pins directly, whatever the isolation bits say
      nxt_state.kbd_wake_data   = kbd_pin_i.data;
      nxt_state.mouse_wake_data = mouse_pin_i.data;

      // slow clock gate: key wake logic sees no edges while switched off
      nxt_state.slow_gated = slow_clock_pin_i
                             && !state_ff.slow_cfg[`KWC_SLOW_KEY_OFF];

      // events into sticky status
      evt_now = 8'h00;
      evt_now[`KWC_EVT_KBD_IRQ]   = kbd_irq_core_i && !state_ff.kbd_core_prev;
      evt_now[`KWC_EVT_MOUSE_IRQ] = mouse_irq_core_i && !state_ff.mouse_core_prev;
      evt_now[`KWC_EVT_KEY_WAKE]  = key_wake_hit_i
                                    && !state_ff.slow_cfg[`KWC_SLOW_KEY_OFF];

      // write one to clear, a new event in the same cycle wins
      if (reg_req_i.wr && hit_stat) begin
         nxt_state.evt_stat = state_ff.evt_stat & ~reg_req_i.wdata;
      end
      nxt_state.evt_stat = nxt_state.evt_stat | evt_now;
      nxt_state.irq = |(nxt_state.evt_stat & nxt_state.evt_mask);
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_ff          <= '0;
         state_ff.kbd_cfg  <= `KWC_KBD_RESET;
         state_ff.slow_cfg <= `KWC_SLOW_RESET;
         state_ff.evt_stat <= `KWC_EVT_RESET;
         state_ff.evt_mask <= `KWC_EVT_RESET;
         state_ff.kbd_core <= '{clk: 1'b1, data: 1'b1};
         state_ff.mouse_core <= '{clk: 1'b1, data: 1'b1};
         state_ff.aux_out  <= 1'b1;  // inactive for the default active low form
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_o            = state_ff.rdata;
   assign kbd_core_o             = state_ff.kbd_core;
   assign mouse_core_o           = state_ff.mouse_core;
   assign kbd_data_line_wake_o   = state_ff.kbd_wake_data;
   assign mouse_data_line_wake_o = state_ff.mouse_wake_data;
   assign aux_port_output_o      = state_ff.aux_out;
   assign kbd_irq_o              = state_ff.kbd_irq;
   assign mouse_irq_o            = state_ff.mouse_irq;
   assign port92_en_o            = state_ff.kbd_cfg[`KWC_KBD_PORT92];
   assign slow_clock_gated_o     = state_ff.slow_gated;
   assign slow_clock_absent_o    = state_ff.slow_cfg[`KWC_SLOW_ABSENT];
   assign key_wake_off_o         = state_ff.slow_cfg[`KWC_SLOW_KEY_OFF];
   assign irq_o                  = state_ff.irq;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // a write to the keyboard select register
   sequence seq_kbd_write;
      reg_req_i.wr && hit_kbd_cfg;
   endsequence

   // a write to the slow clock register
   sequence seq_slow_write;
      reg_req_i.wr && hit_slow_cfg;
   endsequence

   // a read of a reserved keyboard index
   sequence seq_rsv_read;
      reg_req_i.rd && hit_kbd_rsv;
   endsequence

   // a write to a reserved keyboard index
   sequence seq_rsv_write;
      reg_req_i.wr && hit_kbd_rsv;
   endsequence

   a_aux_polarity: assert property (
      ##1 (aux_port_output_o == ($past(state_ff.kbd_cfg[`KWC_KBD_AUX_POL])
           ? $past(aux_port_core_i) : !$past(aux_port_core_i))))
      else $error("aux port output polarity wrong");

   a_mouse_iso_block: assert property (
      state_ff.kbd_cfg[`KWC_KBD_MOUSE_ISO] |=> (mouse_core_o.clk && mouse_core_o.data))
      else $error("mouse lines reached the core while isolated");

   a_key_iso_block: assert property (
      (state_ff.kbd_cfg[`KWC_KBD_KEY_ISO] && !kbd_pin_i.data)
      |=> kbd_core_o.data && kbd_data_line_wake_o == 1'b0)
      else $error("keyboard lines reached the core while isolated");

   // the wake copy is held low in reset, so the cycle after reset is exempt
   a_wake_path_free: assert property (
      ##1 ($past(rst_i) || (kbd_data_line_wake_o == $past(kbd_pin_i.data)
           && mouse_data_line_wake_o == $past(mouse_pin_i.data))))
      else $error("wake data path disturbed");

   a_mouse_wake_iso: assert property (
      (state_ff.kbd_cfg[`KWC_KBD_MOUSE_ISO] && !mouse_pin_i.data)
      |=> mouse_core_o.data && mouse_data_line_wake_o == 1'b0)
      else $error("mouse wake data lost while isolated");

   a_mouse_irq_mux: assert property (
      ##1 (mouse_irq_o == ($past(state_ff.kbd_cfg[`KWC_KBD_MOUSE_IRQ_LATCH_SEL])
           ? $past(state_ff.mouse_latch)
           : ($past(mouse_irq_core_i) && $past(state_ff.mouse_latch)))))
      else $error("mouse irq mux wrong");

   a_kbd_irq_mux: assert property (
      (!state_ff.kbd_cfg[`KWC_KBD_KBD_IRQ_LATCH_SEL] && !kbd_irq_core_i) |=> !kbd_irq_o)
      else $error("keyboard irq high without core irq");

   a_port92_write: assert property (
      seq_kbd_write |=> port92_en_o == $past(reg_req_i.wdata[`KWC_KBD_PORT92]))
      else $error("port 92 enable did not follow write");

   a_reserved_read_zero: assert property (
      seq_rsv_read |=> reg_rdata_o == 8'h00)
      else $error("reserved index read nonzero");

   a_absent_write: assert property (
      seq_slow_write |=> slow_clock_absent_o == $past(reg_req_i.wdata[`KWC_SLOW_ABSENT]))
      else $error("slow clock absent bit did not follow write");

   a_key_off_gate: assert property (
      key_wake_off_o [*2] |-> !slow_clock_gated_o)
      else $error("slow clock passed while key wake off");

   a_key_off_event: assert property (
      (key_wake_off_o && key_wake_hit_i && !state_ff.evt_stat[`KWC_EVT_KEY_WAKE]
       && !(reg_req_i.wr && hit_stat))
      |=> !state_ff.evt_stat[`KWC_EVT_KEY_WAKE])
      else $error("key wake event seen while logic off");

   a_reserved_bits: assert property (
      seq_kbd_write |=> (state_ff.kbd_cfg[1:0] == 2'b00 && $stable(state_ff.slow_cfg)))
      else $error("reserved keyboard bits stored");

   a_slow_reserved_bits: assert property (
      seq_slow_write |=> state_ff.slow_cfg[7:2] == 6'h00)
      else $error("reserved slow clock bits stored");

   a_reserved_write: assert property (
      seq_rsv_write |=> $stable(state_ff.kbd_cfg))
      else $error("reserved index write changed the select register");

endmodule : keyboard_wake_config

`default_nettype wire

// ===== shared/keyboard_wake_config_defines.svh
// register offsets, field positions and reset values of the keyboard wake configuration
`ifndef KEYBOARD_WAKE_CONFIG_DEFINES_SVH
`define KEYBOARD_WAKE_CONFIG_DEFINES_SVH

// ---------------------------------------------------------------
// address map: {logical device, index}
// ---------------------------------------------------------------
`define KWC_LDN_KBD        8'h07
`define KWC_LDN_PME        8'h0a
`define KWC_IDX_CFG        8'hf0
`define KWC_IDX_RSV_LO     8'hf1
`define KWC_IDX_RSV_HI     8'hff
`define KWC_IDX_IRQ_STAT   8'he0
`define KWC_IDX_IRQ_MASK   8'he1

// ---------------------------------------------------------------
// keyboard select register fields
// ---------------------------------------------------------------
`define KWC_KBD_AUX_POL    7
`define KWC_KBD_MOUSE_ISO  6
`define KWC_KBD_KEY_ISO    5
`define KWC_KBD_MOUSE_IRQ_LATCH_SEL     4
`define KWC_KBD_KBD_IRQ_LATCH_SEL     3
`define KWC_KBD_PORT92     2
`define KWC_KBD_WR_MASK    8'hfc
`define KWC_KBD_RESET      8'h00

// ---------------------------------------------------------------
// slow clock register fields
// ---------------------------------------------------------------
`define KWC_SLOW_ABSENT    0
`define KWC_SLOW_KEY_OFF   1
`define KWC_SLOW_WR_MASK   8'h03
`define KWC_SLOW_RESET     8'h00

// ---------------------------------------------------------------
// event status / mask bits
// ---------------------------------------------------------------
`define KWC_EVT_KBD_IRQ    0
`define KWC_EVT_MOUSE_IRQ  1
`define KWC_EVT_KEY_WAKE   2
`define KWC_EVT_WR_MASK    8'h07
`define KWC_EVT_RESET      8'h00

`endif

// ===== shared/keyboard_wake_pkg.sv
// types shared by the keyboard wake configuration block
`default_nettype none

package keyboard_wake_pkg;

   // register port request
   typedef struct packed {
      logic [15:0] addr;   // {logical device, index}
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   // one pair of ps/2 style clock and data lines
   typedef struct packed {
      logic clk;
      logic data;
   } ps2_lines_t;

   // whole state of the block
   typedef struct packed {
      logic [7:0]  kbd_cfg;
      logic [7:0]  slow_cfg;
      logic [7:0]  evt_stat;
      logic [7:0]  evt_mask;
      logic [7:0]  rdata;
      logic        kbd_core_prev;
      logic        mouse_core_prev;
      logic        kbd_latch;
      logic        mouse_latch;
      logic        kbd_irq;
      logic        mouse_irq;
      logic        aux_out;
      ps2_lines_t  kbd_core;
      ps2_lines_t  mouse_core;
      logic        kbd_wake_data;
      logic        mouse_wake_data;
      logic        slow_gated;
      logic        irq;
   } state_t;

endpackage : keyboard_wake_pkg

`default_nettype wire
